// ### rtl/nvac_map.vh
// register map and timing constants for the byte non-volatile access controller
`ifndef NVAC_MAP_VH
`define NVAC_MAP_VH
`define NVAC_CTRL_OFS 8'h40
`define NVAC_SECTOR_CTRL 8'h01
`define NVAC_BIT_FETCH_GO 0
`define NVAC_BIT_FETCH_ALLOW 1
`define NVAC_BIT_PROG_GO 2
`define NVAC_BIT_PROG_ALLOW 3
`define NVAC_CTRL_MASK 8'h0F
`define NVAC_RESET_BYTE 8'h00
`define NVAC_ADDR_MASK_SMALL 8'h7F
`define NVAC_ADDR_MASK_FULL 8'hFF
`define NVAC_READ_CYCLES 4
`define NVAC_WRITE_CYCLES 64
`define NVAC_ST_IDLE 2'b00
`define NVAC_ST_READ 2'b01
`define NVAC_ST_WRITE 2'b10
`endif

// ### rtl/nvac_store.v
// byte storage array with write timer counted in clock_i cycles
`timescale 1ns/1ps
`include "nvac_map.vh"
module nvac_store #(
    parameter WRITE_CYCLES = `NVAC_WRITE_CYCLES
) (
    // clock and reset
    input wire clock_i,
    input wire reset_i,
    // access
    input wire [7:0] addr_i,
    input wire [7:0] wdata_i,
    input wire write_start_i,
    output reg [7:0] rdata_o,
    output wire write_busy_o,
    output reg write_done_o
);
    reg [7:0] mem_q [0:255];
    reg [15:0] timer_q;
    reg [7:0] waddr_q;
    reg [7:0] wbyte_q;

    assign write_busy_o = (timer_q != 16'h0000);

    always @(posedge clock_i) begin
        rdata_o <= mem_q[addr_i];
        if (write_done_o) begin
            mem_q[waddr_q] <= wbyte_q;
        end
    end

    // separate timer paces the write, counting WRITE_CYCLES clock_i cycles
    always @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            timer_q <= 16'h0000;
            waddr_q <= 8'h00;
            wbyte_q <= 8'h00;
            write_done_o <= 1'b0;
        end else begin
            write_done_o <= 1'b0;
            if (write_start_i && !write_busy_o) begin
                timer_q <= WRITE_CYCLES[15:0];
                waddr_q <= addr_i;
                wbyte_q <= wdata_i;
            end else if (write_busy_o) begin
                timer_q <= timer_q - 16'h0001;
                if (timer_q == 16'h0001) begin
                    write_done_o <= 1'b1;
                end
            end
        end
    end
endmodule

// ### rtl/nvac_top.v
// register front end for the byte non-volatile access controller
`timescale 1ns/1ps
`include "nvac_map.vh"
module nvac_top #(
    parameter FULL_SIZE = 1,
    parameter READ_CYCLES = `NVAC_READ_CYCLES,
    parameter WRITE_CYCLES = `NVAC_WRITE_CYCLES
) (
    // clock and reset
    input wire clock_i,
    input wire reset_i,
    // direct special register writes (address and data)
    input wire addr_wr_i,
    input wire data_wr_i,
    input wire [7:0] wdata_i,
    // pointer and indirect access port
    input wire ptr_high_wr_i,
    input wire ptr_low_wr_i,
    input wire indirect_wr_i,
    // interrupt flag service
    input wire done_flag_clr_i,
    input wire mf_flag_ack_i,
    input wire nv_irq_enable_i,
    // register read back
    output wire [7:0] nv_address_o,
    output wire [7:0] nv_data_o,
    output wire [7:0] nv_control_o,
    output wire [7:0] indirect_rdata_o,
    output wire [7:0] pointer_high_byte_o,
    output wire [7:0] pointer_low_byte_o,
    // events
    output wire nv_done_flag_o,
    output wire mf_flag_o,
    output wire nv_irq_o,
    output wire busy_o
);
    localparam [7:0] ADDR_MASK = FULL_SIZE ? `NVAC_ADDR_MASK_FULL : `NVAC_ADDR_MASK_SMALL;
    localparam [7:0] READ_LAST = READ_CYCLES[7:0] - 8'h01;
    localparam CTRL_BITS = 4;

    // =====================================
    // sequencer states
    localparam [1:0] ST_IDLE = `NVAC_ST_IDLE;
    localparam [1:0] ST_READ = `NVAC_ST_READ;
    localparam [1:0] ST_WRITE = `NVAC_ST_WRITE;

    // =====================================
    // registers and next values
    reg [7:0] addr_q;
    reg [7:0] addr_d;
    reg [7:0] data_q;
    reg [7:0] data_d;
    wire [3:0] ctrl_q;
    reg [3:0] ctrl_d;
    reg [7:0] ptr_hi_q;
    reg [7:0] ptr_hi_d;
    reg [7:0] ptr_lo_q;
    reg [7:0] ptr_lo_d;
    reg [1:0] state_q;
    reg [1:0] state_d;
    reg [7:0] rd_cnt_q;
    reg [7:0] rd_cnt_d;
    reg done_q;
    reg done_d;
    reg mf_q;
    reg mf_d;

    // =====================================
    // internal strobes
    wire [7:0] store_rdata;
    wire store_busy;
    wire store_done;
    wire [7:0] store_addr;
    wire ctrl_sel;
    wire ctrl_hit;
    wire [3:0] ctrl_wr;
    wire seq_idle;
    wire write_start;
    wire read_start;
    wire read_last;
    wire write_end;

    // =====================================
    // decode of the indirect port
    assign ctrl_sel = (ptr_hi_q == `NVAC_SECTOR_CTRL)
        && (ptr_lo_q == `NVAC_CTRL_OFS);
    assign ctrl_hit = indirect_wr_i && ctrl_sel;
    assign ctrl_wr = wdata_i[3:0];
    assign seq_idle = (state_q == ST_IDLE);

    // a start needs its enable already set in the register
    assign write_start = seq_idle && ctrl_hit && ctrl_wr[`NVAC_BIT_PROG_GO]
        && ctrl_q[`NVAC_BIT_PROG_ALLOW] && ctrl_wr[`NVAC_BIT_PROG_ALLOW];
    // write wins when both starts arrive together
    assign read_start = seq_idle && ctrl_hit && ctrl_wr[`NVAC_BIT_FETCH_GO]
        && ctrl_q[`NVAC_BIT_FETCH_ALLOW] && !write_start;
    assign read_last = (state_q == ST_READ) && (rd_cnt_q == READ_LAST);
    assign write_end = (state_q == ST_WRITE) && store_done;
    assign store_addr = addr_q & ADDR_MASK;

    // =====================================
    // storage array, one byte per access
    nvac_store #(
        .WRITE_CYCLES(WRITE_CYCLES)
    ) u_store (
        .clock_i(clock_i),
        .reset_i(reset_i),
        .addr_i(store_addr),
        .wdata_i(data_q),
        .write_start_i(write_start),
        .rdata_o(store_rdata),
        .write_busy_o(store_busy),
        .write_done_o(store_done)
    );

    // =====================================
    // pointer pair
    always @* begin
        ptr_hi_d = ptr_hi_q;
        ptr_lo_d = ptr_lo_q;
        if (ptr_high_wr_i) begin
            ptr_hi_d = wdata_i;
        end
        if (ptr_low_wr_i) begin
            ptr_lo_d = wdata_i;
        end
    end

    always @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            ptr_hi_q <= `NVAC_RESET_BYTE;
            ptr_lo_q <= `NVAC_RESET_BYTE;
        end else begin
            ptr_hi_q <= ptr_hi_d;
            ptr_lo_q <= ptr_lo_d;
        end
    end

    // =====================================
    // address and data next values
    always @* begin
        addr_d = addr_q;
        data_d = data_q;
        if (addr_wr_i) begin
            addr_d = wdata_i & ADDR_MASK;
        end
        if (data_wr_i) begin
            data_d = wdata_i;
        end
        // fetched byte then holds until the next load
        if (read_last) begin
            data_d = store_rdata;
        end
    end

    // =====================================
    // control next value
    always @* begin
        ctrl_d = ctrl_q;
        if (ctrl_hit) begin
            // enables always writable
            ctrl_d[`NVAC_BIT_PROG_ALLOW] = ctrl_wr[`NVAC_BIT_PROG_ALLOW];
            ctrl_d[`NVAC_BIT_FETCH_ALLOW] = ctrl_wr[`NVAC_BIT_FETCH_ALLOW];
            // start bits written while busy are ignored
            if (seq_idle) begin
                ctrl_d[`NVAC_BIT_PROG_GO] = write_start;
                ctrl_d[`NVAC_BIT_FETCH_GO] = read_start;
            end
        end
        if (read_last) begin
            ctrl_d[`NVAC_BIT_FETCH_GO] = 1'b0;
        end
        if (write_end) begin
            ctrl_d[`NVAC_BIT_PROG_GO] = 1'b0;
        end
    end

    // control bit flops
    genvar bit_idx;
    generate
        for (bit_idx = 0; bit_idx < CTRL_BITS; bit_idx = bit_idx + 1) begin : g_ctrl_bit
            reg bit_q;
            always @(posedge clock_i or posedge reset_i) begin
                if (reset_i) begin
                    bit_q <= 1'b0;
                end else begin
                    bit_q <= ctrl_d[bit_idx];
                end
            end
            assign ctrl_q[bit_idx] = bit_q;
        end
    endgenerate

    // =====================================
    // sequencer next state
    always @* begin
        state_d = state_q;
        rd_cnt_d = rd_cnt_q;
        case (state_q)
            ST_IDLE: begin
                rd_cnt_d = 8'h00;
                if (write_start) begin
                    state_d = ST_WRITE;
                end else if (read_start) begin
                    state_d = ST_READ;
                end
            end
            ST_READ: begin
                // fixed read length, counted in system clocks
                if (read_last) begin
                    state_d = ST_IDLE;
                end else begin
                    rd_cnt_d = rd_cnt_q + 8'h01;
                end
            end
            ST_WRITE: begin
                // waits on the write timer of the array
                if (store_done) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // =====================================
    // address and data flops
    always @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            addr_q <= `NVAC_RESET_BYTE;
            data_q <= `NVAC_RESET_BYTE;
        end else begin
            addr_q <= addr_d;
            data_q <= data_d;
        end
    end

    // =====================================
    // sequencer flops
    always @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            state_q <= ST_IDLE;
            rd_cnt_q <= 8'h00;
        end else begin
            state_q <= state_d;
            rd_cnt_q <= rd_cnt_d;
        end
    end

    // =====================================
    // completion flags, set wins over clear
    always @* begin
        done_d = store_done | (done_q & ~done_flag_clr_i);
        mf_d = store_done | (mf_q & ~mf_flag_ack_i);
    end

    always @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            done_q <= 1'b0;
            mf_q <= 1'b0;
        end else begin
            done_q <= done_d;
            mf_q <= mf_d;
        end
    end

    // =====================================
    // read back
    assign nv_address_o = addr_q;
    assign nv_data_o = data_q;
    assign nv_control_o = {4'h0, ctrl_q};
    assign indirect_rdata_o = ctrl_sel ? ({4'h0, ctrl_q} & `NVAC_CTRL_MASK) : 8'h00;
    assign pointer_high_byte_o = ptr_hi_q;
    assign pointer_low_byte_o = ptr_lo_q;
    assign nv_done_flag_o = done_q;
    assign mf_flag_o = mf_q;
    assign nv_irq_o = done_q & mf_q & nv_irq_enable_i;
    assign busy_o = (state_q != `NVAC_ST_IDLE) | store_busy;
endmodule

// ### sim/nvac_chk_assertions.sv
// checker for the non-volatile access controller
`timescale 1ns/1ps
module nvac_chk #(
    parameter READ_CYCLES = 4,
    parameter WRITE_CYCLES = 64
) (
    // clock, reset, inputs
    input logic clock_i,
    input logic reset_i,
    input logic indirect_wr_i,
    input logic done_flag_clr_i,
    input logic nv_irq_enable_i,
    input logic [7:0] wdata_i,
    // outputs
    input logic [7:0] nv_control_o,
    input logic [7:0] pointer_high_byte_o,
    input logic [7:0] pointer_low_byte_o,
    input logic nv_done_flag_o,
    input logic mf_flag_o,
    input logic nv_irq_o,
    input logic busy_o
);
    // ====================
    // accepted starts
    localparam int WL = WRITE_CYCLES + 2;
    localparam int RL = READ_CYCLES + 1;
    wire ok_ptr = pointer_high_byte_o == 8'h01 && pointer_low_byte_o == 8'h40;
    wire sel = indirect_wr_i && !busy_o;
    wire wr_go = sel && ok_ptr && nv_control_o[3] && wdata_i[3:2] == 2'b11;
    wire rd_go = sel && ok_ptr && nv_control_o[1] && wdata_i[2:0] == 3'b011;
    default clocking @(posedge clock_i); endclocking
    default disable iff (reset_i);
    a_ctrl_upper: assert property (nv_control_o[7:4] == 4'h0)
        else $error("control upper bits set");
    a_prog_gate: assert property ($rose(nv_control_o[2]) |-> $past(nv_control_o[3]))
        else $error("write start without enable");
    a_fetch_gate: assert property ($rose(nv_control_o[0]) |-> $past(nv_control_o[1]))
        else $error("read start without enable");
    a_write_len: assert property (wr_go |-> ##[WL:WL] !nv_control_o[2] && nv_done_flag_o)
        else $error("write end wrong");
    a_read_len: assert property (rd_go |-> ##[RL:RL] !nv_control_o[0] && !busy_o)
        else $error("read end wrong");
    a_irq_and: assert property (nv_irq_o == (nv_done_flag_o && mf_flag_o && nv_irq_enable_i))
        else $error("irq mismatch");
    a_done_sticky: assert property (nv_done_flag_o && !done_flag_clr_i |=> nv_done_flag_o)
        else $error("done flag lost");
    a_ptr_guard: assert property (sel && !ok_ptr |=> $stable(nv_control_o))
        else $error("control changed via wrong pointer");
endmodule
bind nvac_top nvac_chk #(.READ_CYCLES(READ_CYCLES), .WRITE_CYCLES(WRITE_CYCLES)) u_chk (.*);

// ### sim/nvac_mem_model.sv
// behavioural mirror of the byte storage array
`timescale 1ns/1ps
module nvac_mem_model;
    // ====================
    // storage
    logic [7:0] mem [0:255];
    task automatic put(input logic [7:0] a, input logic [7:0] d);
        mem[a] = d;
    endtask
    function automatic logic [7:0] get(input logic [7:0] a);
        return mem[a];
    endfunction
endmodule

// ### sim/nvac_top_tb.sv
// testbench for the non-volatile access controller
`timescale 1ns/1ps
module nvac_top_tb;
    logic clock_i = 0;
    logic reset_i = 1;
    logic [6:0] stb = '0;
    logic [7:0] wdata = '0;
    logic irq_en = 0;
    wire [7:0] ctrl, addr, data, ptrh, ptrl, ind;
    wire done, mf, irq, busy;
    int mismatches = 0;
    int checks = 0;
    nvac_top #(.FULL_SIZE(1), .READ_CYCLES(4), .WRITE_CYCLES(4)) DUT (
        .clock_i(clock_i), .reset_i(reset_i), .addr_wr_i(stb[0]), .data_wr_i(stb[1]),
        .wdata_i(wdata), .ptr_high_wr_i(stb[2]), .ptr_low_wr_i(stb[3]),
        .indirect_wr_i(stb[4]), .done_flag_clr_i(stb[5]), .mf_flag_ack_i(stb[6]),
        .nv_irq_enable_i(irq_en), .nv_address_o(addr), .nv_data_o(data),
        .nv_control_o(ctrl), .indirect_rdata_o(ind), .pointer_high_byte_o(ptrh),
        .pointer_low_byte_o(ptrl), .nv_done_flag_o(done), .mf_flag_o(mf), .nv_irq_o(irq),
        .busy_o(busy));
    nvac_mem_model u_mem ();
    initial forever #20 clock_i = ~clock_i;
    // ====================
    // tasks
    task automatic wrap_up();
        if (mismatches == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic st(input int k, input logic [7:0] v);
        @(posedge clock_i);
        stb <= 7'h01 << k;
        wdata <= v;
    endtask
    task automatic idle(input int n);
        repeat (n) begin
            @(posedge clock_i);
            stb <= '0;
        end
        #1;
    endtask
    task automatic poll(input int b);
        for (int i = 0; i < 40; i++) begin
            idle(1);
            if (ctrl[b] === 1'b0) return;
        end
        mismatches++;
        wrap_up();
    endtask
    task automatic nv_write(input logic [7:0] a, input logic [7:0] d, input logic en);
        st(0, a);
        irq_en <= en;
        st(1, d);
        st(4, 8'h08);
        st(4, 8'h0C);
        u_mem.put(a, d);
        idle(1);
        chk("busy ctrl", 8'h0C, ctrl);
        chk("busy", 8'h01, {7'h00, busy});
        poll(2);
        chk("busy end", 8'h00, {7'h00, busy});
        chk("ctrl", 8'h08, ctrl);
        chk("flags", 8'h03, {6'h00, done, mf});
        chk("irq", {7'h00, en}, {7'h00, irq});
        st(5, 8'h00);
        st(6, 8'h00);
        idle(1);
        chk("flags clr", 8'h00, {6'h00, done, mf});
    endtask
    task automatic nv_read(input logic [7:0] a);
        st(4, 8'h02);
        st(0, a);
        st(4, 8'h03);
        poll(0);
        chk("rdata", u_mem.get(a), data);
        chk("ctrl", 8'h02, ctrl);
    endtask
    // ====================
    // sequence
    initial begin
        repeat (4) @(posedge clock_i);
        reset_i <= 0;
        idle(1);
        chk("ctrl rst", 8'h00, ctrl);
        chk("ptrh rst", 8'h00, ptrh);
        chk("addr rst", 8'h00, addr);
        chk("data rst", 8'h00, data);
        st(2, 8'h01);
        st(3, 8'h41);
        st(4, 8'h08);
        idle(1);
        chk("bad ptr", 8'h00, ctrl);
        chk("ptrl", 8'h41, ptrl);
        chk("bad ptr rd", 8'h00, ind);
        st(3, 8'h40);
        st(4, 8'h04);
        idle(1);
        chk("go no allow", 8'h00, ctrl);
        st(4, 8'h01);
        idle(1);
        chk("fetch no allow", 8'h00, ctrl);
        st(4, 8'hFA);
        idle(1);
        chk("upper", 8'h0A, ind);
        st(4, 8'h04);
        idle(1);
        chk("allow dropped", 8'h00, ctrl);
        nv_write(8'hFF, 8'hA5, 1'b1);
        nv_write(8'h00, 8'h5A, 1'b0);
        st(1, 8'h33);
        nv_read(8'hFF);
        st(0, 8'h10);
        idle(5);
        chk("held", 8'hA5, data);
        nv_read(8'h00);
        wrap_up();
    end
endmodule
